// *** logic/bsk_exec.sv ***
// What this block does
// - opcode 0101 sets bit b of register f; flags untouched; one cycle.
// - opcode 0110 reads bit b of register f; skip next when zero.
// - successful skip-if-clear drops fetched word, runs nop; two cycles.
// - opcode 0111 reads bit b of register f; skip next when one.
// - successful skip-if-set drops prefetched word, runs nop; else one cycle.
`timescale 1ns/10ps
`include "bsk_map.svh"
module bsk_exec
	import bsk_pkg::*;
#(
	parameter int NUM_REGS = 32
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        instr_valid,
	input  wire logic [11:0] instr,
	output logic             busy_reg,
	output logic             skip_reg,
	output logic             nop_reg,
	output logic             wr_en_reg,
	output logic [4:0]       wr_addr_reg,
	output logic [7:0]       wr_data_reg,
	output logic [11:0]      exec_word_reg,
	output logic [7:0]       status_reg
);
	logic [7:0]  file_mem [NUM_REGS];
	bsk_op_t     op;
	logic [2:0]  bit_idx;
	logic [4:0]  addr;
	logic [7:0]  sel_mask;
	logic        tested_bit;
	logic        skip_hit;
	logic        set_hit;
	logic        flushing;
	logic        take_skip;
	logic        active;
	bsk_state_t  state_reg;
	bsk_state_t  state_next;

	bsk_decode u_dec
	(
		.instr   (instr),
		.op      (op),
		.bit_idx (bit_idx),
		.addr    (addr)
	);

	// one-hot mask of the chosen bit, shared by the test and the set
	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
	begin
		bit_mask = 8'h01 << idx;
	end
	endfunction

	assign flushing   = state_reg == BSK_ST_FLUSH;
	assign active     = instr_valid && !flushing;
	assign sel_mask   = bit_mask(bit_idx);
	assign tested_bit = |(file_mem[addr] & sel_mask);
	assign set_hit    = active && (op == BSK_OP_BIT_SET);
	assign take_skip  = active && skip_hit;

	// test outcome for the two skip forms
	always_comb
	begin
		skip_hit = 1'b0;
		unique case (op)
			BSK_OP_SKIP_CLEAR: skip_hit = !tested_bit;
			BSK_OP_SKIP_SET:   skip_hit = tested_bit;
			BSK_OP_BIT_SET:    skip_hit = 1'b0;
			BSK_OP_NONE:       skip_hit = 1'b0;
		endcase
	end

	// a taken skip spends one extra cycle flushing the fetched word
	always_comb
	begin
		unique case (state_reg)
			BSK_ST_RUN:   state_next = take_skip ? BSK_ST_FLUSH : BSK_ST_RUN;
			BSK_ST_FLUSH: state_next = BSK_ST_RUN;
			default:      state_next = BSK_ST_RUN;
		endcase
	end

	// run or flush state
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= BSK_ST_RUN;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// file registers, cleared on reset so every test reads a known bit
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				file_mem[i] <= 8'h00;
		end
		else if (set_hit)
		begin
			file_mem[addr] <= file_mem[addr] | sel_mask;
		end
	end

	// write port mirror, enable
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_en_reg <= 1'b0;
		end
		else
		begin
			wr_en_reg <= set_hit;
		end
	end

	// write port mirror, address
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_addr_reg <= 5'h00;
		end
		else
		begin
			wr_addr_reg <= addr;
		end
	end

	// write port mirror, new register value
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_data_reg <= 8'h00;
		end
		else
		begin
			wr_data_reg <= file_mem[addr] | sel_mask;
		end
	end

	// executed word, discarded fetch becomes nop
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			exec_word_reg <= `BSK_NOP_WORD;
		end
		else if (flushing)
		begin
			exec_word_reg <= `BSK_NOP_WORD;
		end
		else
		begin
			exec_word_reg <= instr;
		end
	end

	// nop substituted for the discarded word
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			nop_reg <= 1'b0;
		end
		else
		begin
			nop_reg <= flushing && instr_valid;
		end
	end

	// taken skip pulse
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			skip_reg <= 1'b0;
		end
		else
		begin
			skip_reg <= take_skip;
		end
	end

	// high during the flush cycle
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			busy_reg <= 1'b0;
		end
		else
		begin
			busy_reg <= state_next == BSK_ST_FLUSH;
		end
	end

	// no flag is altered by these three operations
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			status_reg <= 8'h00;
		end
		else
		begin
			status_reg <= status_reg;
		end
	end
endmodule

// *** pkg/bsk_map.svh ***
`ifndef BSK_MAP_SVH
`define BSK_MAP_SVH
`define BSK_OPC_BIT_SET     4'h5
`define BSK_OPC_SKIP_CLEAR  4'h6
`define BSK_OPC_SKIP_SET    4'h7
`define BSK_OPC_MSB         11
`define BSK_OPC_LSB         8
`define BSK_BIT_MSB         7
`define BSK_BIT_LSB         5
`define BSK_ADDR_MSB        4
`define BSK_ADDR_LSB        0
`define BSK_NOP_WORD        12'h000
`endif

// *** pkg/bsk_pkg.sv ***
package bsk_pkg;
	typedef enum logic [3:0] {
		BSK_OP_NONE       = 4'b0001,
		BSK_OP_BIT_SET    = 4'b0010,
		BSK_OP_SKIP_CLEAR = 4'b0100,
		BSK_OP_SKIP_SET   = 4'b1000
	} bsk_op_t;
	typedef enum logic [1:0] {
		BSK_ST_RUN   = 2'b01,
		BSK_ST_FLUSH = 2'b10
	} bsk_state_t;
endpackage

// *** logic/bsk_decode.sv ***
`timescale 1ns/10ps
`include "bsk_map.svh"
module bsk_decode
	import bsk_pkg::*;
(
	input  wire logic [11:0] instr,
	output bsk_op_t          op,
	output logic [2:0]       bit_idx,
	output logic [4:0]       addr
);
	always_comb
	begin
		bit_idx = instr[`BSK_BIT_MSB:`BSK_BIT_LSB];
		addr    = instr[`BSK_ADDR_MSB:`BSK_ADDR_LSB];
		unique case (instr[`BSK_OPC_MSB:`BSK_OPC_LSB])
			`BSK_OPC_BIT_SET:    op = BSK_OP_BIT_SET;
			`BSK_OPC_SKIP_CLEAR: op = BSK_OP_SKIP_CLEAR;
			`BSK_OPC_SKIP_SET:   op = BSK_OP_SKIP_SET;
			default:             op = BSK_OP_NONE;
		endcase
	end
endmodule

// *** tb/bsk_exec_sva.sv ***
`timescale 1ns/10ps
module bsk_exec_sva
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        instr_valid,
	input wire logic [11:0] instr,
	input wire logic        busy_reg,
	input wire logic        skip_reg,
	input wire logic        nop_reg,
	input wire logic        wr_en_reg,
	input wire logic [4:0]  wr_addr_reg,
	input wire logic [7:0]  wr_data_reg,
	input wire logic [11:0] exec_word_reg,
	input wire logic [7:0]  status_reg
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire take = instr_valid && !busy_reg;
	property p_set; take && instr[11:8] == 4'h5 |=> wr_en_reg && !skip_reg
		&& wr_addr_reg == $past(instr[4:0]) && wr_data_reg[$past(instr[7:5])]; endproperty
	a_set: assert property (p_set) else $error("bit set write wrong");
	property p_flag; status_reg == 8'h00; endproperty
	a_flag: assert property (p_flag) else $error("flags changed");
	property p_cause; skip_reg |-> $past(take && instr[11:9] == 3'b011); endproperty
	a_cause: assert property (p_cause) else $error("skip without test");
	property p_nop; skip_reg && instr_valid |=> nop_reg && exec_word_reg == 12'h000
		&& !wr_en_reg; endproperty
	a_nop: assert property (p_nop) else $error("skipped word not dropped");
	property p_busy; skip_reg |-> busy_reg ##1 !busy_reg; endproperty
	a_busy: assert property (p_busy) else $error("skip not two cycles");
	property p_single; take && instr[11:8] == 4'h5 |=> !busy_reg; endproperty
	a_single: assert property (p_single) else $error("bit set took two cycles");
	property p_flush; busy_reg |=> !wr_en_reg && !skip_reg; endproperty
	a_flush: assert property (p_flush) else $error("flushed word executed");
endmodule
bind bsk_exec bsk_exec_sva u_sva (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
	.instr(instr), .busy_reg(busy_reg), .skip_reg(skip_reg), .nop_reg(nop_reg),
	.wr_en_reg(wr_en_reg), .wr_addr_reg(wr_addr_reg), .wr_data_reg(wr_data_reg),
	.exec_word_reg(exec_word_reg), .status_reg(status_reg));

// *** tb/bsk_exec_tb.sv ***
`timescale 1ns/10ps
`include "bsk_map.svh"
module bsk_exec_tb;
	logic        sys_clk = 0, rst = 1, instr_valid = 0, bz, sk, np, we;
	logic [11:0] instr = 12'h000, ew;
	logic [7:0]  wd, st;
	logic [4:0]  wa;
	int          mismatches = 0, checks_done = 0, cyc = 0;
	bsk_exec dut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
		.busy_reg(bz), .skip_reg(sk), .nop_reg(np), .wr_en_reg(we), .wr_addr_reg(wa),
		.wr_data_reg(wd), .exec_word_reg(ew), .status_reg(st));
	initial forever #2.5 sys_clk = ~sys_clk;
	task chk(input string n, input logic [11:0] e, input logic [11:0] g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task wrap_up;
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task put(input logic [11:0] w, input logic v);
		@(posedge sys_clk);
		#1 instr = w;
		instr_valid = v;
	endtask
	task t_set(input logic [11:0] w, input logic [4:0] a, input int b, input logic [7:0] d);
		put(w, 1);
		put(w, 0);
		chk("wr_en", 1, we);
		chk("wr_addr", a, wa);
		chk("wr_bit", 1, wd[b]);
		chk("wr_data", d, wd);
		chk("busy", 0, bz);
		chk("status", 0, st);
	endtask
	task t_skip(input logic [11:0] w, input logic s);
		put(w, 1);
		put(12'h51f, 1);
		chk("skip", s, sk);
		chk("busy", s, bz);
		put(12'h51f, 0);
		chk("nop", s, np);
		chk("exec_word", s ? `BSK_NOP_WORD : 12'h51f, ew);
		chk("wr_en", !s, we);
		chk("busy_end", 0, bz);
		chk("status", 0, st);
	endtask
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 500)
		begin
			mismatches++;
			wrap_up;
		end
	end
	initial
	begin
		repeat (20) @(posedge sys_clk);
		#1 rst = 0;
		t_set(12'h5e3, 5'h03, 7, 8'h80);
		t_set(12'h51f, 5'h1f, 0, 8'h01);
		t_skip(12'h7e3, 1);
		t_skip(12'h6e3, 0);
		t_skip(12'h71f, 1);
		t_skip(12'h6c3, 1);
		t_skip(12'h7c3, 0);
		wrap_up;
	end
endmodule
